// *** design/bpp_flash_dev.sv ***
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// R1: Unlock clears write bits except locked-down ones
// R2: Host sends write enable before unlock
// R3: Unlock is opcode 98H only, then CS high
// R4: Bits 47:32 are read/write pairs, 8K blocks
// R5: Bits 31,30 protect the 32K blocks
// R6: Bits 0..29 protect 64K blocks from 010000H
// R7: Reset value is 5555 FFFF FFFF
// R8: Lock-down bits program once, stay locked
// R9: Sleep command ignored while write busy
// R10: In sleep, only release command is obeyed
// R11: Sleep opcode B9H, entered at CS rise
// R12: Host ends prior frame, ends with CS high
// R13: Sleep reached within 3 us
// R14: Standby within 10 us after release
// R15: No sleep while program or erase busy
// R16: Write enable sets the latch
// R17: Release opcode ABH returns to standby
// R18: Reject program/erase into protected block
// R19: Unlock clears the write enable latch
module bpp_flash_dev
  import bpp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bpp_link_if.device link,
  output logic [47:0] prot_o,
  output logic [47:0] lockdown_o,
  output logic wel_o,
  output logic busy_o,
  output logic asleep_o,
  output logic ready_o,
  output logic reject_o
);
  typedef enum logic [1:0] {BPP_ST_AWAKE, BPP_ST_ENTER, BPP_ST_SLEEP,
    BPP_ST_WAKE} bpp_pwr_type;

  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic ck_s1_r, ck_s2_r, ck_d_r;
  logic si_s1_r, si_s2_r;
  logic [63:0] sh_r;
  logic [6:0] nbit_r;
  logic [47:0] prot_r, lock_r;
  logic wel_r, reject_r;
  logic [BPP_CNT_W-1:0] busy_cnt_r, pwr_cnt_r;
  bpp_pwr_type pwr_r;
  logic ck_rise, frame_end;
  logic [7:0] op;
  logic [23:0] addr;
  logic [47:0] wmask;
  logic hit;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_d_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= link.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      ck_s1_r <= link.sck;
      ck_s2_r <= ck_s1_r;
      ck_d_r <= ck_s2_r;
      si_s1_r <= link.si;
      si_s2_r <= si_s1_r;
    end
  end

  assign ck_rise = ck_s2_r && !ck_d_r && !cs_s2_r;
  assign frame_end = cs_s2_r && !cs_d_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r <= '0;
      nbit_r <= '0;
    end else if (ck_rise) begin
      sh_r <= {sh_r[62:0], si_s2_r};
      if (nbit_r != 7'h7F) begin
        nbit_r <= nbit_r + 7'h01;
      end
    end else if (frame_end) begin
      nbit_r <= '0;
    end
  end

  // Opcode is the first byte; frames hold op only, op+addr, or op+48 bits
  always_comb begin
    op = 8'h00;
    addr = 24'h000000;
    wmask = 48'h0;
    if (nbit_r == 7'd8) begin
      op = sh_r[7:0]; // R3
    end else if (nbit_r == 7'd32) begin
      op = sh_r[31:24];
      addr = sh_r[23:0];
    end else if (nbit_r == 7'd56) begin
      op = sh_r[55:48];
      wmask = sh_r[47:0];
    end
  end

  // Block lookup by address
  always_comb begin
    hit = 1'b0;
    if (addr >= 24'h1F8000) begin
      hit = prot_r[6'd40 + {3'b000, addr[14:13], 1'b0}]; // R4
    end else if (addr < 24'h008000) begin
      hit = prot_r[6'd32 + {3'b000, addr[14:13], 1'b0}]; // R4
    end else if (addr >= 24'h1F0000) begin
      hit = prot_r[31]; // R5
    end else if (addr < 24'h010000) begin
      hit = prot_r[30]; // R5
    end else begin
      hit = prot_r[5'(addr[20:16] - 5'd1)]; // R6
    end
  end

  logic obey;
  assign obey = frame_end && (pwr_r == BPP_ST_AWAKE); // R10

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prot_r <= BPP_PROT_RST; // R7
      lock_r <= '0;
      wel_r <= 1'b0;
      reject_r <= 1'b0;
      busy_cnt_r <= '0;
    end else begin
      reject_r <= 1'b0;
      if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      if (obey && busy_cnt_r == '0) begin
        unique case (op)
          BPP_OP_WR_EN: wel_r <= 1'b1; // R16
          BPP_OP_WRDI: wel_r <= 1'b0;
          BPP_OP_UNLOCK: begin
            if (wel_r) begin // R2
              for (int i = 0; i < 48; i++) begin
                // Read-lock bits are untouched by unlock
                if ((i >= 32 ? (i % 2 == 0) : 1'b1) && !lock_r[i]) begin
                  prot_r[i] <= 1'b0; // R1 R8
                end
              end
              wel_r <= 1'b0; // R19
            end
          end
          BPP_OP_LOCKDOWN: begin
            if (wel_r) begin
              lock_r <= lock_r | (wmask & prot_r); // R8
              wel_r <= 1'b0;
              busy_cnt_r <= BPP_CNT_W'(BPP_BUSY_CYC);
            end
          end
          BPP_OP_PROG, BPP_OP_ERASE: begin
            if (wel_r && !hit) begin
              busy_cnt_r <= BPP_CNT_W'(BPP_BUSY_CYC);
            end else begin
              reject_r <= wel_r; // R18
            end
            wel_r <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_r <= BPP_ST_AWAKE;
      pwr_cnt_r <= '0;
    end else begin
      unique case (pwr_r)
        BPP_ST_AWAKE: begin
          // R11 R9 R15
          if (obey && op == BPP_OP_SLEEP && busy_cnt_r == '0) begin
            pwr_r <= BPP_ST_ENTER;
            pwr_cnt_r <= BPP_CNT_W'(BPP_SLEEP_ENTRY_CYC - BPP_SYNC_LAG);
          end
        end
        BPP_ST_ENTER: begin
          if (pwr_cnt_r == '0) begin
            pwr_r <= BPP_ST_SLEEP; // R13
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
          end
        end
        BPP_ST_SLEEP: begin
          if (frame_end && op == BPP_OP_WAKE) begin // R17 R10
            pwr_r <= BPP_ST_WAKE;
            pwr_cnt_r <= BPP_CNT_W'(BPP_WAKE_CYC - BPP_SYNC_LAG);
          end
        end
        BPP_ST_WAKE: begin
          if (pwr_cnt_r == '0) begin
            pwr_r <= BPP_ST_AWAKE; // R14
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign prot_o = prot_r;
  assign lockdown_o = lock_r;
  assign wel_o = wel_r;
  assign busy_o = busy_cnt_r != '0;
  assign asleep_o = pwr_r == BPP_ST_SLEEP;
  assign ready_o = pwr_r == BPP_ST_AWAKE;
  assign reject_o = reject_r;
endmodule

// *** design/bpp_pkg.sv ***
package bpp_pkg;
  localparam int BPP_CMD_W = 8;
  localparam logic [7:0] BPP_OP_WR_EN = 8'h06;
  localparam logic [7:0] BPP_OP_UNLOCK = 8'h98;
  localparam logic [7:0] BPP_OP_SLEEP = 8'hB9;
  localparam logic [7:0] BPP_OP_WAKE = 8'hAB;
  localparam logic [7:0] BPP_OP_WRDI = 8'h04;
  localparam logic [7:0] BPP_OP_PROG = 8'h02;
  localparam logic [7:0] BPP_OP_ERASE = 8'h20;
  localparam logic [7:0] BPP_OP_LOCKDOWN = 8'hE8;
  localparam int BPP_PROT_W = 48;
  localparam logic [47:0] BPP_PROT_RST = 48'h5555_FFFF_FFFF;
  localparam int BPP_ADDR_W = 24;
  localparam int BPP_CLK_MHZ = 100;
  localparam int BPP_SLEEP_ENTRY_US = 3;
  localparam int BPP_WAKE_US = 10;
  // Longest times round down
  localparam int BPP_SLEEP_ENTRY_CYC = BPP_SLEEP_ENTRY_US * BPP_CLK_MHZ;
  localparam int BPP_WAKE_CYC = BPP_WAKE_US * BPP_CLK_MHZ;
  // Pin sync plus decode eat this many cycles of each timing limit
  localparam int BPP_SYNC_LAG = 4;
  // Outlasts a one-byte frame, so an order can land mid-write
  localparam int BPP_BUSY_CYC = 200;
  localparam int BPP_HALF_DIV = 4;
  localparam int BPP_CNT_W = 12;
  // Host register offsets
  localparam logic [3:0] BPP_REG_CMD = 4'h0;
  localparam logic [3:0] BPP_REG_ADDR = 4'h1;
  localparam logic [3:0] BPP_REG_STAT = 4'h2;
  localparam logic [3:0] BPP_REG_PROT_LO = 4'h3;
  localparam logic [3:0] BPP_REG_PROT_HI = 4'h4;
endpackage

// *** design/bpp_link_if.sv ***
`timescale 1ns/1ps
interface bpp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  modport device (input cs_n, input sck, input si);
  modport host (output cs_n, output sck, output si);
endinterface

// *** design/bpp_flash_host.sv ***
`timescale 1ns/1ps
module bpp_flash_host
  import bpp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bpp_link_if.host link,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  typedef enum logic [1:0] {BPP_H_IDLE, BPP_H_LOW, BPP_H_HIGH,
    BPP_H_GAP} bpp_host_type;

  bpp_host_type st_r;
  logic [63:0] sh_r;
  logic [6:0] left_r;
  logic [3:0] div_r;
  logic [23:0] addr_r;
  logic [47:0] data_r;
  logic sck_r, cs_n_r, done_r;
  logic [31:0] rdata_r;
  logic go;
  logic [1:0] len;

  // Write to CMD: [7:0] opcode, [9:8] 0=op, 1=op+addr, 2=op+48 data
  assign go = wr_i && addr_i == BPP_REG_CMD && st_r == BPP_H_IDLE;
  assign len = wdata_i[9:8];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= '0;
      data_r <= '0;
    end else if (wr_i) begin
      if (addr_i == BPP_REG_ADDR) begin
        addr_r <= wdata_i[23:0];
      end
      if (addr_i == BPP_REG_PROT_LO) begin
        data_r[31:0] <= wdata_i;
      end
      if (addr_i == BPP_REG_PROT_HI) begin
        data_r[47:32] <= wdata_i[15:0];
      end
    end
  end

  // Each frame opens from CS high and ends with CS high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= BPP_H_IDLE;
      sh_r <= '0;
      left_r <= '0;
      div_r <= '0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      unique case (st_r)
        BPP_H_IDLE: begin
          div_r <= '0;
          if (go) begin // R12
            cs_n_r <= 1'b0;
            done_r <= 1'b0;
            st_r <= BPP_H_LOW;
            if (len == 2'd1) begin
              sh_r <= {wdata_i[7:0], addr_r, 32'h0};
              left_r <= 7'd32;
            end else if (len == 2'd2) begin
              sh_r <= {wdata_i[7:0], data_r, 8'h00};
              left_r <= 7'd56;
            end else begin
              sh_r <= {wdata_i[7:0], 56'h0}; // R3 R11 R17
              left_r <= 7'd8;
            end
          end
        end
        BPP_H_LOW: begin
          if (div_r == 4'(BPP_HALF_DIV - 1)) begin
            div_r <= '0;
            sck_r <= 1'b1;
            st_r <= BPP_H_HIGH;
          end
        end
        BPP_H_HIGH: begin
          if (div_r == 4'(BPP_HALF_DIV - 1)) begin
            div_r <= '0;
            sck_r <= 1'b0;
            sh_r <= {sh_r[62:0], 1'b0};
            left_r <= left_r - 7'd1;
            st_r <= (left_r == 7'd1) ? BPP_H_GAP : BPP_H_LOW;
          end
        end
        BPP_H_GAP: begin
          if (div_r == 4'(BPP_HALF_DIV - 1)) begin
            cs_n_r <= 1'b1; // R12
            done_r <= 1'b1;
            st_r <= BPP_H_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (rd_i && addr_i == BPP_REG_STAT) begin
      rdata_r <= {30'h0, done_r, st_r != BPP_H_IDLE};
    end else if (rd_i && addr_i == BPP_REG_ADDR) begin
      rdata_r <= {8'h00, addr_r};
    end else begin
      rdata_r <= '0;
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.si = sh_r[63];
  assign rdata_o = rdata_r;
endmodule

// *** verif/bpp_chk.sv ***
`timescale 1ns/1ps
module bpp_chk
  import bpp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic [47:0] prot_o,
  input wire logic [47:0] lockdown_o,
  input wire logic wel_o,
  input wire logic busy_o,
  input wire logic asleep_o,
  input wire logic ready_o
);
  logic sck_r, cs_q_r;
  logic [7:0] op_r;
  logic [5:0] nbit_r;
  logic [10:0] wake_cnt_r;
  logic frame_ok;
  // Last byte shifted is the opcode only when the frame is 8 bits long
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_r <= 1'b0;
      cs_q_r <= 1'b1;
      op_r <= 8'h00;
      nbit_r <= 6'h00;
      wake_cnt_r <= 11'h000;
    end else begin
      sck_r <= sck;
      cs_q_r <= cs_n;
      if (cs_n) begin
        nbit_r <= 6'h00;
      end else if (sck && !sck_r) begin
        op_r <= {op_r[6:0], si};
        nbit_r <= nbit_r + 6'h01;
      end
      // Cycles since the wake frame ended, until the device is ready
      if (cs_n && !cs_q_r && nbit_r == 6'h08 && op_r == BPP_OP_WAKE &&
          asleep_o) begin
        wake_cnt_r <= 11'h001;
      end else if (wake_cnt_r != 11'h000 && !ready_o) begin
        wake_cnt_r <= wake_cnt_r + 11'h001;
      end else begin
        wake_cnt_r <= 11'h000;
      end
    end
  end
  assign frame_ok = nbit_r == 6'h08 && ready_o && !busy_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_value_a: assert property (
    $rose(rst_n_i) |-> prot_o == BPP_PROT_RST) else $error("bad reset value");
  lock_held_a: assert property (
    (lockdown_o & ~prot_o) == 48'h0) else $error("locked block unprotected");
  lock_sticky_a: assert property (
    (lockdown_o & $past(lockdown_o)) == $past(lockdown_o))
    else $error("lock bit cleared");
  busy_no_sleep_a: assert property (
    asleep_o |-> !busy_o) else $error("asleep while busy");
  sleep_deaf_a: assert property (
    asleep_o |-> !ready_o) else $error("ready while asleep");
  sck_idle_a: assert property (
    cs_n |-> !sck) else $error("clock moves outside frame");
  sleep_entry_a: assert property (
    $rose(cs_n) && frame_ok && op_r == BPP_OP_SLEEP |-> ##[1:300] asleep_o)
    else $error("sleep not entered in time");
  wake_time_a: assert property (
    wake_cnt_r <= 11'h3E8) else $error("wake too slow");
  sleep_busy_a: assert property (
    $rose(cs_n) && nbit_r == 6'h08 && op_r == BPP_OP_SLEEP && ready_o &&
    busy_o ##2 busy_o |=> ready_o) else $error("sleep taken while busy");
  write_enable_cmd_sets_a: assert property (
    $rose(cs_n) && frame_ok && op_r == BPP_OP_WR_EN |-> ##[1:8] wel_o)
    else $error("write enable not set");
  unlock_clear_a: assert property (
    $rose(cs_n) && frame_ok && wel_o && op_r == BPP_OP_UNLOCK |-> ##[1:8]
    (!wel_o && (prot_o & ~lockdown_o & 48'h5555_FFFF_FFFF) == 48'h0))
    else $error("unlock result wrong");
  cover property ($rose(asleep_o));
  cover property ($rose(ready_o));
  cover property ($fell(wel_o));
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import bpp_pkg::*;
  logic core_clk_i, rst_n_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [47:0] prot_o, lockdown_o;
  logic wel_o, busy_o, asleep_o, ready_o, reject_o;
  int miscompares, checks_done, rejects;
  bpp_link_if link();
  bpp_flash_dev bpp_flash_dev_i(.core_clk_i, .rst_n_i, .link(link), .prot_o,
    .lockdown_o, .wel_o, .busy_o, .asleep_o, .ready_o, .reject_o);
  bpp_flash_host bpp_flash_host_i(.core_clk_i, .rst_n_i, .link(link),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  bpp_chk bpp_chk_i(.core_clk_i, .rst_n_i, .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .prot_o, .lockdown_o, .wel_o, .busy_o, .asleep_o, .ready_o);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (reject_o === 1'b1) rejects++;
  task chk(input string name, input logic [47:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge core_clk_i);
  endtask
  // Polls the host status so no order is written while a frame is out
  task cmd(input logic [9:0] c);
    logic [31:0] s;
    int n;
    wr(BPP_REG_CMD, {22'h0, c});
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 500) begin
      rd(BPP_REG_STAT, s);
      n++;
    end
    if (s[0] !== 1'b0) miscompares++;
    chk("host status", {16'h0, s}, 48'h2);
    repeat (8) @(posedge core_clk_i);
  endtask
  task t_reset;
    logic [31:0] d;
    chk("prot", prot_o, BPP_PROT_RST);
    rd(4'hF, d);
    chk("unmapped", {16'h0, d}, 48'h0);
    cmd({2'h0, BPP_OP_UNLOCK});
    chk("prot no write_enable_cmd", prot_o, BPP_PROT_RST);
  endtask
  task t_lock_unlock;
    cmd({2'h0, BPP_OP_WR_EN});
    chk("wel", {47'h0, wel_o}, 48'h1);
    wr(BPP_REG_PROT_LO, 32'h0000_0001);
    wr(BPP_REG_PROT_HI, 32'h0000_4000);
    cmd({2'h2, BPP_OP_LOCKDOWN});
    repeat (240) @(posedge core_clk_i);
    chk("lockdown", lockdown_o, 48'h4000_0000_0001);
    cmd({2'h0, BPP_OP_WR_EN});
    cmd({2'h0, BPP_OP_UNLOCK});
    chk("prot unlocked", prot_o, 48'h4000_0000_0001);
    chk("wel cleared", {47'h0, wel_o}, 48'h0);
  endtask
  task t_program;
    logic [31:0] d;
    rejects = 0;
    cmd({2'h0, BPP_OP_WR_EN});
    wr(BPP_REG_ADDR, 32'h0001_0000);
    rd(BPP_REG_ADDR, d);
    chk("addr reg", {16'h0, d}, 48'h0001_0000);
    cmd({2'h1, BPP_OP_PROG});
    chk("reject locked", 48'(rejects), 48'h1);
    cmd({2'h0, BPP_OP_WR_EN});
    wr(BPP_REG_ADDR, 32'h0002_0000);
    cmd({2'h1, BPP_OP_PROG});
    chk("busy", {47'h0, busy_o}, 48'h1);
    chk("reject open", 48'(rejects), 48'h1);
    // The write still runs, so this sleep order must be ignored
    cmd({2'h0, BPP_OP_SLEEP});
    chk("no sleep busy", {46'h0, asleep_o, ready_o}, 48'h1);
    repeat (240) @(posedge core_clk_i);
  endtask
  task t_sleep;
    cmd({2'h0, BPP_OP_SLEEP});
    repeat (300) @(posedge core_clk_i);
    chk("asleep", {asleep_o, ready_o}, 48'h2);
    cmd({2'h0, BPP_OP_WR_EN});
    chk("wel asleep", {47'h0, wel_o}, 48'h0);
    cmd({2'h0, BPP_OP_WAKE});
    repeat (1000) @(posedge core_clk_i);
    chk("awake", {asleep_o, ready_o}, 48'h1);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_lock_unlock();
    t_program();
    t_sleep();
    report_and_stop();
  end
endmodule
